/* File: core/tarb_register_bank.sv */
// Thermal alarm register bank with its serial bus slave
`timescale 1ns/10ps
`include "tarb_map.svh"
module tarb_register_bank #(
   parameter logic [6:0] SLAVE_ADDR = 7'h2a   // Arbitrary bus address
) (
   input  wire logic                i_clk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_smb_clk,
   input  wire logic                i_smb_data,
   input  wire tarb_pkg::tarb_byte_t i_remote_temp,
   input  wire tarb_pkg::tarb_byte_t i_local_temp,
   input  wire logic                i_meas_valid,
   output logic                     o_smb_data_oe,
   output logic                     o_over_temp_alarm_n_oe,
   output tarb_pkg::tarb_byte_t     o_configuration
);
   import tarb_pkg::*;

   tarb_line_if line ();

   tarb_pin_sync u_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_scl     (i_smb_clk),
      .i_sda     (i_smb_data),
      .line      (line.src)
   );

   tarb_state_t state_reg;
   tarb_state_t state_next;
   tarb_kind_t  kind_reg;
   tarb_kind_t  kind_next;
   logic [3:0]  cnt_reg;
   logic [3:0]  cnt_next;
   tarb_byte_t  shift_reg;
   tarb_byte_t  shift_next;
   tarb_byte_t  tx_reg;
   tarb_byte_t  tx_next;
   tarb_byte_t  ptr_reg;
   tarb_byte_t  ptr_next;
   logic        read_reg;
   logic        read_next;
   logic        mack_reg;
   logic        mack_next;
   logic        oe_next;
   logic        wr_en;

   tarb_byte_t  remote_temp_reg;
   tarb_byte_t  local_temp_reg;
   tarb_byte_t  config_reg;
   tarb_byte_t  remote_limit_reg;
   tarb_byte_t  local_limit_reg;
   tarb_flags_t status_reg;
   tarb_flags_t status_next;
   tarb_flags_t mask_reg;
   tarb_flags_t mask_next;
   tarb_flags_t fault;
   tarb_byte_t  rd_byte;

   wire byte_end  = line.scl_fall && (state_reg == ST_RECV) && (cnt_reg == `TARB_BITS_PER_BYTE);
   wire addr_hit  = (shift_reg[7:1] == SLAVE_ADDR);
   wire send_last = (cnt_reg == `TARB_BITS_PER_BYTE);
   wire tx_load   = line.scl_fall && (((state_reg == ST_ACK) && read_reg) ||
                                      ((state_reg == ST_MACK) && mack_reg));
   wire status_rd = tx_load && (ptr_reg == `TARB_OFS_STATUS);
   wire sel_cfg   = (ptr_reg == `TARB_OFS_CONFIG);
   wire sel_rlim  = (ptr_reg == `TARB_OFS_REMOTE_LIMIT);
   wire sel_llim  = (ptr_reg == `TARB_OFS_LOCAL_LIMIT);
   wire sel_mask  = (ptr_reg == `TARB_OFS_MASK);

   // Read mux; unmapped offsets return zero
   assign rd_byte =
      (ptr_reg == `TARB_OFS_REMOTE_TEMP) ? remote_temp_reg :                   // [R1] [R3]
      (ptr_reg == `TARB_OFS_LOCAL_TEMP)  ? local_temp_reg :                    // [R2] [R3]
      sel_cfg                            ? config_reg :
      sel_rlim                           ? remote_limit_reg :
      sel_llim                           ? local_limit_reg :
      (ptr_reg == `TARB_OFS_STATUS)      ? {status_reg, `TARB_FLAG_PAD} :
      sel_mask                           ? {mask_reg, `TARB_FLAG_PAD} :
      8'h00;

   // Channel above its limit at a fresh measurement
   assign fault[`TARB_BIT_REMOTE] = i_meas_valid && (i_remote_temp > remote_limit_reg); // [R7]
   assign fault[`TARB_BIT_LOCAL]  = i_meas_valid && (i_local_temp > local_limit_reg);   // [R7]

   // Set beats the read-clear, so a fault in the read cycle survives
   assign status_next = fault | (status_rd ? `TARB_RST_STATUS : status_reg); // [R9] [R10] [R11] [R13]
   assign mask_next   = (wr_en && sel_mask) ? shift_reg[7:6] : mask_reg;

   always_comb begin
      state_next = state_reg;
      kind_next  = kind_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      tx_next    = tx_reg;
      ptr_next   = ptr_reg;
      read_next  = read_reg;
      mack_next  = mack_reg;
      oe_next    = o_smb_data_oe;
      wr_en      = 1'b0;
      if (line.start) begin
         // Repeated start lands here too, keeping the command pointer
         state_next = ST_RECV;
         kind_next  = K_ADDR;
         cnt_next   = `TARB_CNT_ZERO;
         oe_next    = 1'b0;
      end else if (line.stop) begin
         state_next = ST_IDLE;
         oe_next    = 1'b0;
      end else begin
         case (state_reg)
            ST_RECV: begin
               if (line.scl_rise && (cnt_reg != `TARB_BITS_PER_BYTE)) begin
                  shift_next = {shift_reg[6:0], line.sda};
                  cnt_next   = cnt_reg + `TARB_CNT_ONE;
               end else if (byte_end) begin
                  state_next = ST_ACK;
                  oe_next    = 1'b1;
                  case (kind_reg)
                     K_ADDR: begin
                        read_next = shift_reg[0];                            // [R17] [R18]
                        if (!addr_hit) begin
                           state_next = ST_SKIP;
                           oe_next    = 1'b0;
                        end
                     end
                     K_CMD: begin
                        ptr_next = shift_reg;                                // [R17] [R18]
                     end
                     default: begin
                        wr_en = 1'b1;                                        // [R17]
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (line.scl_fall) begin
                  if (read_reg) begin
                     // Receive-byte and read-byte both use the last command
                     state_next = ST_SEND;                                   // [R18]
                     tx_next    = rd_byte;
                     oe_next    = ~rd_byte[7];                               // [R4]
                     cnt_next   = `TARB_CNT_ONE;
                  end else begin
                     state_next = ST_RECV;
                     oe_next    = 1'b0;
                     cnt_next   = `TARB_CNT_ZERO;
                     kind_next  = (kind_reg == K_ADDR) ? K_CMD : K_DATA;
                  end
               end
            end
            ST_SEND: begin
               if (line.scl_fall) begin
                  if (send_last) begin
                     state_next = ST_MACK;
                     oe_next    = 1'b0;
                  end else begin
                     tx_next  = {tx_reg[6:0], 1'b0};                         // [R4]
                     oe_next  = ~tx_reg[6];
                     cnt_next = cnt_reg + `TARB_CNT_ONE;
                  end
               end
            end
            ST_MACK: begin
               if (line.scl_rise) begin
                  mack_next = ~line.sda;
               end else if (line.scl_fall) begin
                  if (mack_reg) begin
                     // Host acked: stream the same register again
                     state_next = ST_SEND;
                     tx_next    = rd_byte;
                     oe_next    = ~rd_byte[7];
                     cnt_next   = `TARB_CNT_ONE;
                  end else begin
                     state_next = ST_SKIP;                                   // [R18]
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_reg     <= ST_IDLE;
         kind_reg      <= K_ADDR;
         cnt_reg       <= `TARB_CNT_ZERO;
         shift_reg     <= 8'h00;
         tx_reg        <= 8'h00;
         ptr_reg       <= `TARB_OFS_REMOTE_TEMP;
         read_reg      <= 1'b0;
         mack_reg      <= 1'b0;
         o_smb_data_oe <= 1'b0;
      end else begin
         state_reg     <= state_next;
         kind_reg      <= kind_next;
         cnt_reg       <= cnt_next;
         shift_reg     <= shift_next;
         tx_reg        <= tx_next;
         ptr_reg       <= ptr_next;
         read_reg      <= read_next;
         mack_reg      <= mack_next;
         o_smb_data_oe <= oe_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         remote_temp_reg <= `TARB_RST_TEMP;                                  // [R5]
         local_temp_reg  <= `TARB_RST_TEMP;                                  // [R5]
      end else if (i_meas_valid) begin
         remote_temp_reg <= i_remote_temp;                                   // [R1]
         local_temp_reg  <= i_local_temp;                                    // [R2]
      end
   end

   // Temperature and status registers ignore writes
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         config_reg       <= `TARB_RST_CONFIG;                               // [R6]
         remote_limit_reg <= `TARB_RST_REMOTE_LIMIT;                         // [R8]
         local_limit_reg  <= `TARB_RST_LOCAL_LIMIT;                          // [R8]
      end else if (wr_en) begin
         if (sel_cfg) begin
            config_reg <= shift_reg;                                         // [R6]
         end else if (sel_rlim) begin
            remote_limit_reg <= shift_reg;                                   // [R7]
         end else if (sel_llim) begin
            local_limit_reg <= shift_reg;                                    // [R7]
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         status_reg             <= `TARB_RST_STATUS;                         // [R15]
         mask_reg               <= `TARB_RST_MASK;
         o_over_temp_alarm_n_oe <= 1'b0;
         o_configuration        <= `TARB_RST_CONFIG;
      end else begin
         status_reg             <= status_next;
         mask_reg               <= mask_next;
         // Pin pulled low while any unmasked status bit stands
         o_over_temp_alarm_n_oe <= |(status_next & ~mask_next);              // [R7] [R12] [R16]
         o_configuration        <= (wr_en && sel_cfg) ? shift_reg : config_reg; // [R6]
      end
   end

   a_temp_reset: assert property (@(posedge i_clk) i_sys_rst |=>  // [R5]
      remote_temp_reg == `TARB_RST_TEMP && local_temp_reg == `TARB_RST_TEMP)
      else $error("temperature registers not zero after reset");
   a_temp_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R1]
      i_meas_valid |=> remote_temp_reg == $past(i_remote_temp)
                       && local_temp_reg == $past(i_local_temp))
      else $error("measurement not stored");
   a_limit_reset: assert property (@(posedge i_clk) i_sys_rst |=>  // [R8]
      remote_limit_reg == `TARB_RST_REMOTE_LIMIT && local_limit_reg == `TARB_RST_LOCAL_LIMIT
      && o_configuration == `TARB_RST_CONFIG)
      else $error("limit or configuration reset value wrong");
   a_status_reset: assert property (@(posedge i_clk) i_sys_rst |=>  // [R15]
      status_reg == `TARB_RST_STATUS && !o_over_temp_alarm_n_oe)
      else $error("status not clear after reset");
   a_remote_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R9]
      i_meas_valid && (i_remote_temp > remote_limit_reg) |=> status_reg[`TARB_BIT_REMOTE])
      else $error("remote fault not flagged");
   a_local_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R10]
      i_meas_valid && (i_local_temp > local_limit_reg) |=> status_reg[`TARB_BIT_LOCAL])
      else $error("local fault not flagged");
   a_status_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R11]
      status_reg[`TARB_BIT_REMOTE] && !status_rd |=> status_reg[`TARB_BIT_REMOTE])
      else $error("status cleared without a read");
   a_read_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R12]
      status_rd && !i_meas_valid |=> status_reg == `TARB_RST_STATUS && !o_over_temp_alarm_n_oe)
      else $error("status read did not release alarm");
   a_alarm_mask: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R16]
      ##1 o_over_temp_alarm_n_oe == |(status_reg & ~mask_reg))
      else $error("alarm does not follow unmasked status");
   a_msb_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R4]
      tx_load && !line.start && !line.stop |=> o_smb_data_oe == ~tx_reg[7])
      else $error("first data bit is not the MSB");
   a_config_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R6]
      wr_en && sel_cfg |=> o_configuration == $past(shift_reg) ##1 config_reg == o_configuration)
      else $error("configuration write lost");
   a_temp_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R1] [R2]
      !i_meas_valid |=> $stable(remote_temp_reg) && $stable(local_temp_reg))
      else $error("temperature changed without a measurement");
   a_limit_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R7]
      wr_en && sel_rlim |=> remote_limit_reg == $past(shift_reg))
      else $error("remote limit write lost");
   a_local_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R11]
      status_reg[`TARB_BIT_LOCAL] && !status_rd |=> status_reg[`TARB_BIT_LOCAL])
      else $error("local status cleared without a read");
   a_addr_ack: assert property (@(posedge i_clk) disable iff (i_sys_rst)  // [R17]
      byte_end && kind_reg == K_ADDR && addr_hit && !line.start && !line.stop
      |=> o_smb_data_oe)
      else $error("own address not acknowledged");

   c_status_read:  cover property (@(posedge i_clk) status_rd && o_over_temp_alarm_n_oe);
   c_alarm_rise:   cover property (@(posedge i_clk) $rose(o_over_temp_alarm_n_oe));
   c_limit_write:  cover property (@(posedge i_clk) wr_en && sel_rlim);
   c_multi_read:   cover property (@(posedge i_clk) state_reg == ST_MACK && mack_reg ##1 tx_load);
   c_addr_miss:    cover property (@(posedge i_clk) byte_end && kind_reg == K_ADDR && !addr_hit);
endmodule

/* File: core/tarb_map.svh */
// Register map, field positions, reset values and counts of the thermal alarm register bank
// Overview of operation
// R1: Remote diode temperature result is readable at offset 00h.
// R2: Local ambient temperature result is readable at offset 01h.
// R3: Temperature bytes are binary weighted, MSB 128 C, LSB 1 C.
// R4: Temperature bytes go out on the serial bus MSB first.
// R5: Both temperature registers read zero after reset until first measurement.
// R6: Configuration byte at 02h steers timeout and fan output, resets to zero.
// R7: Unmasked channel above its limit (03h remote, 04h local) pulls alarm low.
// R8: Reset loads remote limit 6Eh and local limit 50h.
// R9: Remote channel fault sets status bit D7.
// R10: Local channel fault sets status bit D6.
// R11: Status bits clear only when the host reads the status register.
// R12: Reading the status register releases the alarm output.
// R13: A persisting fault at the next measurement sets status and alarm again.
// R14: Host reads a temperature register after reading the status register.
// R15: Status register reads zero right after reset.
// R16: Mask bit D7 blocks remote alarms, D6 blocks local alarms.
// R17: Writes use write-byte: address+W, command, data, each acknowledged, stop.
// R18: Reads use read-byte with repeated start, or receive-byte from last command.
`ifndef TARB_MAP_SVH
`define TARB_MAP_SVH

`define TARB_OFS_REMOTE_TEMP   8'h00
`define TARB_OFS_LOCAL_TEMP    8'h01
`define TARB_OFS_CONFIG        8'h02
`define TARB_OFS_REMOTE_LIMIT  8'h03
`define TARB_OFS_LOCAL_LIMIT   8'h04
`define TARB_OFS_STATUS        8'h05
`define TARB_OFS_MASK          8'h06

`define TARB_RST_TEMP          8'h00
`define TARB_RST_CONFIG        8'h00
`define TARB_RST_REMOTE_LIMIT  8'h6e
`define TARB_RST_LOCAL_LIMIT   8'h50
`define TARB_RST_STATUS        2'h0
`define TARB_RST_MASK          2'h0

`define TARB_BIT_REMOTE        1
`define TARB_BIT_LOCAL         0
`define TARB_FLAG_PAD          6'h00

`define TARB_BITS_PER_BYTE     4'h8
`define TARB_CNT_ZERO          4'h0
`define TARB_CNT_ONE           4'h1

`endif

/* File: core/tarb_pkg.sv */
// Types shared by the thermal alarm register bank
package tarb_pkg;
   typedef logic [7:0] tarb_byte_t;
   typedef logic [1:0] tarb_flags_t;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RECV,
      ST_ACK,
      ST_SEND,
      ST_MACK,
      ST_SKIP
   } tarb_state_t;
   typedef enum logic [1:0] {
      K_ADDR,
      K_CMD,
      K_DATA
   } tarb_kind_t;
endpackage

/* File: core/tarb_line_if.sv */
// Filtered serial bus levels and events passed from the pin filter to the register bank
`timescale 1ns/10ps
interface tarb_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport src (output scl, output sda, output scl_rise, output scl_fall,
                output start, output stop);
   modport snk (input scl, input sda, input scl_rise, input scl_fall,
                input start, input stop);
endinterface

/* File: core/tarb_pin_sync.sv */
// Three-stage pin filter and bus event detector for the serial clock and data pins
`timescale 1ns/10ps
module tarb_pin_sync (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_scl,
   input  wire logic i_sda,
   tarb_line_if.src  line
);
   import tarb_pkg::*;

   logic [1:0] pin_in;
   logic [1:0] ff1_reg;
   logic [1:0] ff2_reg;
   logic [1:0] ff3_reg;
   logic [1:0] lvl_reg;
   logic [1:0] lvl_next;
   logic       rise_reg;
   logic       fall_reg;
   logic       start_reg;
   logic       stop_reg;

   assign pin_in = {i_sda, i_scl};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         // Level moves only once stages two and three agree
         assign lvl_next[g] = (ff2_reg[g] == ff3_reg[g]) ? ff3_reg[g] : lvl_reg[g];
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               ff1_reg[g] <= 1'b1;
               ff2_reg[g] <= 1'b1;
               ff3_reg[g] <= 1'b1;
               lvl_reg[g] <= 1'b1;
            end else begin
               ff1_reg[g] <= pin_in[g];
               ff2_reg[g] <= ff1_reg[g];
               ff3_reg[g] <= ff2_reg[g];
               lvl_reg[g] <= lvl_next[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rise_reg  <= 1'b0;
         fall_reg  <= 1'b0;
         start_reg <= 1'b0;
         stop_reg  <= 1'b0;
      end else begin
         rise_reg  <= ~lvl_reg[0] & lvl_next[0];
         fall_reg  <= lvl_reg[0] & ~lvl_next[0];
         start_reg <= lvl_reg[0] & lvl_next[0] & lvl_reg[1] & ~lvl_next[1];
         stop_reg  <= lvl_reg[0] & lvl_next[0] & ~lvl_reg[1] & lvl_next[1];
      end
   end

   // Pulses land together with the new level, so the FSM samples settled data
   assign line.scl      = lvl_reg[0];
   assign line.sda      = lvl_reg[1];
   assign line.scl_rise = rise_reg;
   assign line.scl_fall = fall_reg;
   assign line.start    = start_reg;
   assign line.stop     = stop_reg;
endmodule

/* File: bench/tarb_host_model.sv */
// Bus host model driving the open-drain serial clock and data lines
`timescale 1ns/10ps
module tarb_host_model
   import tarb_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a   // Arbitrary bus address
) (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl_oe,
   output logic      o_sda_oe
);
   logic [6:0] addr;
   initial begin
      o_scl_oe = 1'b0;
      o_sda_oe = 1'b0;
      addr     = DEV_ADDR;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // Ten-clock phases stay clear of the pin filter delay
   task automatic bit_io(input logic b, output logic r);
      o_sda_oe = ~b;
      gap(10);
      o_scl_oe = 1'b0;
      gap(5);
      r = i_sda;
      gap(5);
      o_scl_oe = 1'b1;
   endtask
   // Also serves as repeated start, since the clock is held low between bytes
   task automatic start_cond();
      o_sda_oe = 1'b0;
      gap(10);
      o_scl_oe = 1'b0;
      gap(10);
      o_sda_oe = 1'b1;
      gap(10);
      o_scl_oe = 1'b1;
   endtask
   task automatic stop_cond();
      o_sda_oe = 1'b1;
      gap(10);
      o_scl_oe = 1'b0;
      gap(10);
      o_sda_oe = 1'b0;
      gap(10);
   endtask
   task automatic byte_io(input tarb_byte_t tx, output tarb_byte_t rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic reg_write(input tarb_byte_t cmd, input tarb_byte_t data, output logic ok);
      tarb_byte_t rx;
      logic       a0;
      logic       a1;
      logic       a2;
      start_cond();
      byte_io({addr, 1'b0}, rx, a0);
      byte_io(cmd, rx, a1);
      byte_io(data, rx, a2);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask
   task automatic reg_read(input tarb_byte_t cmd, output tarb_byte_t data, output logic ok);
      tarb_byte_t rx;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       nk;
      start_cond();
      byte_io({addr, 1'b0}, rx, a0);
      byte_io(cmd, rx, a1);
      start_cond();
      byte_io({addr, 1'b1}, rx, a2);
      byte_io(8'hff, data, nk);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask
   task automatic recv_byte(output tarb_byte_t data, output logic ok);
      tarb_byte_t rx;
      logic       nk;
      start_cond();
      byte_io({addr, 1'b1}, rx, ok);
      byte_io(8'hff, data, nk);
      stop_cond();
   endtask
   // Host ack after the first byte asks for the same register again
   task automatic recv_pair(output tarb_byte_t d0, output tarb_byte_t d1, output logic ok);
      tarb_byte_t rx;
      logic       r;
      start_cond();
      byte_io({addr, 1'b1}, rx, ok);
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d0[i] = r;
      end
      bit_io(1'b0, r);
      byte_io(8'hff, d1, r);
      stop_cond();
   endtask
endmodule

/* File: bench/thermal_alarm_register_bank_tb.sv */
// Self-checking bench for the thermal alarm register bank
`timescale 1ns/10ps
module thermal_alarm_register_bank_tb;
   import tarb_pkg::*;
   logic       clk = 1'b0;
   logic       sys_rst;
   logic       meas_valid;
   tarb_byte_t remote_temp;
   tarb_byte_t local_temp;
   tarb_byte_t cfg_out;
   logic       scl_oe;
   logic       sda_oe;
   logic       dut_sda_oe;
   logic       alarm_oe;
   tarb_byte_t rd;
   tarb_byte_t rd2;
   logic       ok;
   int         err_total = 0;
   int         checks_done = 0;
   int         cycles = 0;
   tarb_byte_t rst_exp [0:7] = '{8'h00, 8'h00, 8'h00, 8'h6e, 8'h50, 8'h00, 8'h00, 8'h00};
   // Pull-ups on both bus lines and on the alarm pin
   wire smb_clk  = ~scl_oe;
   wire smb_data = ~(sda_oe | dut_sda_oe);
   wire alarm_n  = ~alarm_oe;
   always #4 clk = ~clk;
   tarb_register_bank u_dut (
      .i_clk                  (clk),
      .i_sys_rst              (sys_rst),
      .i_smb_clk              (smb_clk),
      .i_smb_data             (smb_data),
      .i_remote_temp          (remote_temp),
      .i_local_temp           (local_temp),
      .i_meas_valid           (meas_valid),
      .o_smb_data_oe          (dut_sda_oe),
      .o_over_temp_alarm_n_oe (alarm_oe),
      .o_configuration        (cfg_out)
   );
   tarb_host_model u_host (
      .i_clk    (clk),
      .i_sda    (smb_data),
      .o_scl_oe (scl_oe),
      .o_sda_oe (sda_oe)
   );
   task chk(input tarb_byte_t seen, input tarb_byte_t exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task rdchk(input tarb_byte_t cmd, input tarb_byte_t exp, input string msg);
      u_host.reg_read(cmd, rd, ok);
      chk({7'h00, ok}, 8'h01, "read ack");
      chk(rd, exp, msg);
      // Host duty: a temperature read follows every status read
      if (cmd == 8'h05)
         u_host.reg_read(8'h00, rd, ok);
   endtask
   task wr(input tarb_byte_t cmd, input tarb_byte_t data);
      u_host.reg_write(cmd, data, ok);
      chk({7'h00, ok}, 8'h01, "write ack");
   endtask
   task meas(input tarb_byte_t r, input tarb_byte_t l);
      @(negedge clk);
      remote_temp = r;
      local_temp  = l;
      meas_valid  = 1'b1;
      @(negedge clk);
      meas_valid = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Run needs about 30k cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         $display("CHECK FAILED at %0t: timeout", $time);
         tally_and_finish();
      end
   end
   initial begin
      sys_rst     = 1'b1;
      meas_valid  = 1'b0;
      remote_temp = 8'h00;
      local_temp  = 8'h00;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      repeat (6) @(negedge clk);
      chk(cfg_out, 8'h00, "config pin reset");
      chk({7'h00, alarm_n}, 8'h01, "alarm idle");
      for (int i = 0; i < 8; i++)
         rdchk(8'(i), rst_exp[i], "reset value");
      $display("test reset_values done");
      wr(8'h02, 8'h3c);
      rdchk(8'h02, 8'h3c, "config readback");
      chk(cfg_out, 8'h3c, "config pin");
      wr(8'h00, 8'h55);
      rdchk(8'h00, 8'h00, "read-only remote");
      rdchk(8'h03, 8'h6e, "limit before receive");
      u_host.recv_byte(rd, ok);
      chk(rd, 8'h6e, "receive byte");
      chk({7'h00, ok}, 8'h01, "receive ack");
      u_host.recv_pair(rd, rd2, ok);
      chk({7'h00, ok}, 8'h01, "stream ack");
      chk(rd, 8'h6e, "stream first");
      chk(rd2, 8'h6e, "stream repeat");
      u_host.addr = 7'h2b;
      u_host.reg_write(8'h02, 8'hff, ok);
      chk({7'h00, ok}, 8'h00, "foreign address acked");
      u_host.addr = 7'h2a;
      rdchk(8'h02, 8'h3c, "config after foreign write");
      $display("test access done");
      meas(8'h6f, 8'h50);
      chk({7'h00, alarm_n}, 8'h00, "remote alarm");
      rdchk(8'h00, 8'h6f, "remote temp");
      rdchk(8'h01, 8'h50, "local temp");
      wr(8'h05, 8'h00);
      meas(8'h6f, 8'h51);
      rdchk(8'h05, 8'hc0, "status both");
      chk({7'h00, alarm_n}, 8'h01, "alarm released");
      rdchk(8'h05, 8'h00, "status cleared");
      rdchk(8'h00, 8'h6f, "follow-up temp read");
      meas(8'h6f, 8'h50);
      chk({7'h00, alarm_n}, 8'h00, "alarm again");
      rdchk(8'h05, 8'h80, "status again");
      $display("test status done");
      wr(8'h04, 8'h20);
      meas(8'h00, 8'h20);
      chk({7'h00, alarm_n}, 8'h01, "equal to limit");
      meas(8'h00, 8'h21);
      chk({7'h00, alarm_n}, 8'h00, "above new limit");
      rdchk(8'h05, 8'h40, "local status");
      wr(8'h06, 8'h80);
      rdchk(8'h06, 8'h80, "mask readback");
      meas(8'h6f, 8'h00);
      chk({7'h00, alarm_n}, 8'h01, "remote masked");
      rdchk(8'h05, 8'h80, "masked status");
      meas(8'h00, 8'h21);
      chk({7'h00, alarm_n}, 8'h00, "local unmasked");
      $display("test limits_mask done");
      tally_and_finish();
   end
endmodule
